//--- logic/srs_pkg.sv
// Constants and types shared by the standby and reset sequencer
package srs_pkg;
   // System clock rate in kHz (10 MHz, 100 ns period)
   localparam int CLK_KHZ = 10000;
   // One modulo-timer tick is 64 us
   localparam int TICK_NS = 64000;
   localparam int TICK_CYC = TICK_NS * CLK_KHZ / 1000000;
   // Reset pin must stay low longer than 10 us
   localparam int RST_MIN_NS = 10000;
   localparam int RST_CYC = (RST_MIN_NS * CLK_KHZ + 999999) / 1000000;
   // Standby instruction operands
   localparam logic [3:0] OPND_TMR = 4'h2;
   localparam logic [3:0] OPND_KEY = 4'h8;
   // Reset values
   localparam logic [7:0] MOD_RST = 8'hFF;
   localparam logic [15:0] DBF_RST = 16'h0320;

   // Sequencer states
   typedef enum logic [2:0] {
      S_RUN,
      S_HALT02,
      S_HALT08,
      S_STOP,
      S_WAIT,
      S_RST
   } srs_state_t;

   // Standby instruction from the core
   typedef struct packed {
      logic valid;
      logic stop;
      logic [3:0] operand;
   } srs_cmd_t;

   // One bit per interrupt source
   typedef struct packed {
      logic tmr;
      logic itv;
      logic ext;
   } srs_irq_t;
endpackage

//--- logic/srs_standby_seq.sv
// Standby and reset sequencer: halt/stop gating, wake and timed restart
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Halt whose operand condition fails is a no-op, no halt entered.
// - Halt 02H enters halt only while the timer request flag is clear.
// - Halt 08H needs enabled flags clear and all used key inputs high.
// - Stop halts oscillation and execution until a release event.
// - Stop 08H released by a low key input or enabled pin-edge request.
// - On stop release clear timer flag, restart timers; match resumes.
// - After stop release the core is held in halt during the wait.
// - Release wait lasts modulo value plus one ticks of 64 us.
// - Stop whose operand condition fails is a no-op, oscillator runs.
// - Stop 08H needs keys high and enabled pin request flag clear.
// - Reset pin held low longer than 10 us resets the device.
// - Oscillator off during reset; timed wait then start at address 0.
// - Reset clears PC, flags, peripherals and loads buffer with 0320H.
// - Edge select 0 picks rising, 1 picks falling pin edge.
module srs_standby_seq #(
   parameter int TICK_CYCLES = srs_pkg::TICK_CYC // Clock cycles per tick
) (
   input wire logic clock_i, // 10 MHz system clock
   input wire logic srst_i, // Synchronous chip reset
   input wire logic rst_pin_n_i, // Reset pin, low resets
   input wire srs_pkg::srs_cmd_t cmd_i, // Standby instruction
   input wire logic [3:0] key_port_a_i, // Key port A pins
   input wire logic [11:0] key_bcd_i, // Key ports B to D pins
   input wire logic [11:0] key_bcd_used_i, // B to D bits used as input
   input wire logic int_pin_i, // External interrupt pin
   input wire logic edge_select_flag_i, // 0 rising, 1 falling
   input wire srs_pkg::srs_irq_t irq_en_i, // Per-source enables
   input wire logic global_irq_en_i, // Interrupts globally enabled
   input wire logic interval_timer_req_flag_i, // Interval timer request
   input wire logic tmr_flag_clr_i, // Clear timer request flag
   input wire logic ext_flag_clr_i, // Clear pin request flag
   input wire logic mod_wr_i, // Load modulo value
   input wire logic [7:0] mod_data_i, // New modulo value
   input wire logic dbf_wr_i, // Load data buffer
   input wire logic [15:0] dbf_data_i, // New data buffer word
   output logic cmd_nop_o, // Instruction treated as no-op
   output logic core_hold_o, // Core stopped (halt, stop, wait, reset)
   output logic osc_run_o, // Oscillator running
   output logic itv_timer_run_o, // Interval/watchdog timer running
   output logic resume_o, // Core resumes this cycle
   output logic branch_irq_o, // Resume through interrupt vector
   output logic core_reset_o, // Clear PC, flags, peripherals
   output logic timer_req_flag_o, // 8-bit timer request flag
   output logic ext_req_flag_o, // Pin interrupt request flag
   output logic [7:0] modulo_value_o, // Modulo register
   output logic [15:0] data_buffer_word_o // Data buffer
);
   import srs_pkg::*;

   localparam int PW = 18;
   localparam int RW = $clog2(RST_CYC + 1);
   localparam int DW = $clog2(TICK_CYCLES);
   localparam logic [RW-1:0] RST_LIM = RW'(RST_CYC);
   localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

   srs_state_t state_reg, state_next;
   logic [PW-1:0] pin_s;
   logic [RW-1:0] low_cnt_reg;
   logic [DW-1:0] div_reg;
   logic [7:0] tmr_cnt_reg;
   logic [7:0] modulo_value_reg;
   logic [15:0] dbf_reg;
   logic timer_req_flag_reg;
   logic ext_flag_reg;
   logic int_prev_reg;
   logic wake_irq_reg, wake_irq_next;
   logic resume, branch, nop, restart;

   ////////////////////////////////////////////////////////////////////////
   // All pins pass the three-stage filter in one vector
   srs_sync3 #(.W(PW), .RST_VAL({PW{1'b1}})) u_sync (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .d_i({rst_pin_n_i, int_pin_i, key_bcd_i, key_port_a_i}),
      .q_o(pin_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pin decode; unused B to D bits count as high
   wire logic [3:0] key_a_s;
   wire logic [11:0] key_bcd_s;
   wire logic int_s;
   wire logic rst_low;
   wire logic key_all_high;
   wire logic key_low;
   assign key_a_s = pin_s[3:0];
   assign key_bcd_s = pin_s[15:4];
   assign int_s = pin_s[16];
   assign rst_low = ~pin_s[17];
   assign key_all_high = (&key_a_s) & (&(key_bcd_s | ~key_bcd_used_i));
   assign key_low = ~key_all_high;

   // Reset pin qualified only after more than the minimum low time
   wire logic pin_rst;
   assign pin_rst = rst_low && (low_cnt_reg == RST_LIM);

   // Internal initialisation from either reset source
   wire logic init;
   assign init = srst_i | (state_reg == S_RST);

   // Pin edge picked by the edge select flag
   wire logic ext_hit;
   assign ext_hit = edge_select_flag_i ? (int_prev_reg & ~int_s)
                                       : (~int_prev_reg & int_s);

   ////////////////////////////////////////////////////////////////////////
   // Timebase: the divider only runs while the oscillator runs, so
   // stop and reset freeze the divider and 8-bit timer, as a dead oscillator would
   wire logic osc_run;
   wire logic tick;
   wire logic match_tick;
   assign osc_run = (state_reg != S_STOP) && (state_reg != S_RST);
   assign tick = osc_run && (div_reg == DIV_LAST);
   assign match_tick = tick && (tmr_cnt_reg == modulo_value_reg);

   // Entry conditions for each operand
   wire logic [2:0] flags;
   wire logic en_pend;
   wire logic halt02_ok;
   wire logic halt08_ok;
   wire logic stop_ok;
   wire logic ext_wake;
   assign flags = {timer_req_flag_reg, interval_timer_req_flag_i,
                   ext_flag_reg};
   assign en_pend = |(irq_en_i & flags);
   assign halt02_ok = (cmd_i.operand == OPND_TMR) &&
                      !timer_req_flag_reg;
   assign halt08_ok = (cmd_i.operand == OPND_KEY) && !en_pend &&
                      key_all_high;
   assign stop_ok = (cmd_i.operand == OPND_KEY) && key_all_high &&
                    !(irq_en_i.ext && ext_flag_reg);
   assign ext_wake = irq_en_i.ext && ext_flag_reg;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer next state; a qualified reset pin overrides everything
   always_comb begin
      state_next = state_reg;
      wake_irq_next = wake_irq_reg;
      resume = 1'b0;
      branch = 1'b0;
      nop = 1'b0;
      restart = 1'b0;
      case (state_reg)
         S_RUN: begin
            if (cmd_i.valid) begin
               if (cmd_i.stop) begin
                  if (stop_ok) begin
                     state_next = S_STOP;
                  end else begin
                     nop = 1'b1;
                  end
               end else if (halt02_ok) begin
                  state_next = S_HALT02;
               end else if (halt08_ok) begin
                  state_next = S_HALT08;
               end else begin
                  nop = 1'b1;
               end
            end
         end
         S_HALT02: begin
            if (timer_req_flag_reg) begin
               state_next = S_RUN;
               resume = 1'b1;
               branch = global_irq_en_i && irq_en_i.tmr;
            end
         end
         S_HALT08: begin
            if (key_low) begin
               state_next = S_RUN;
               resume = 1'b1;
            end else if (en_pend) begin
               state_next = S_RUN;
               resume = 1'b1;
               branch = global_irq_en_i;
            end
         end
         S_STOP: begin
            if (key_low || ext_wake) begin
               state_next = S_WAIT;
               restart = 1'b1;
               wake_irq_next = ext_wake && !key_low;
            end
         end
         S_WAIT: begin
            if (match_tick) begin
               state_next = S_RUN;
               resume = 1'b1;
               branch = wake_irq_reg && global_irq_en_i;
            end
         end
         S_RST: begin
            if (!rst_low) begin
               state_next = S_WAIT;
               restart = 1'b1;
               wake_irq_next = 1'b0;
            end
         end
         default: begin
            state_next = S_RUN;
         end
      endcase
      if (pin_rst) begin
         state_next = S_RST;
         resume = 1'b0;
         branch = 1'b0;
         nop = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State and reset-pin timing
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         state_reg <= S_WAIT;
         wake_irq_reg <= 1'b0;
         low_cnt_reg <= '0;
         int_prev_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         wake_irq_reg <= wake_irq_next;
         int_prev_reg <= int_s;
         if (!rst_low) begin
            low_cnt_reg <= '0;
         end else if (low_cnt_reg != RST_LIM) begin
            low_cnt_reg <= low_cnt_reg + RW'(1);
         end
      end
   end

   // Divider and 8-bit timer; restart clears both so the wait is exact
   always_ff @(posedge clock_i) begin
      if (init || restart) begin
         div_reg <= '0;
         tmr_cnt_reg <= 8'h00;
      end else if (osc_run) begin
         div_reg <= tick ? '0 : div_reg + DW'(1);
         if (match_tick) begin
            tmr_cnt_reg <= 8'h00;
         end else if (tick) begin
            tmr_cnt_reg <= tmr_cnt_reg + 8'h01;
         end
      end
   end

   // Request flags: a hardware set wins over any clear in that cycle
   always_ff @(posedge clock_i) begin
      if (init) begin
         timer_req_flag_reg <= 1'b0;
         ext_flag_reg <= 1'b0;
      end else begin
         if (match_tick) begin
            timer_req_flag_reg <= 1'b1;
         end else if (restart || tmr_flag_clr_i) begin
            timer_req_flag_reg <= 1'b0;
         end
         if (ext_hit) begin
            ext_flag_reg <= 1'b1;
         end else if (ext_flag_clr_i) begin
            ext_flag_reg <= 1'b0;
         end
      end
   end

   // Modulo and data buffer take their defaults on every reset
   always_ff @(posedge clock_i) begin
      if (init) begin
         modulo_value_reg <= MOD_RST;
         dbf_reg <= DBF_RST;
      end else begin
         if (mod_wr_i) begin
            modulo_value_reg <= mod_data_i;
         end
         if (dbf_wr_i) begin
            dbf_reg <= dbf_data_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs; the interval timer resumes without being cleared
   assign cmd_nop_o = nop;
   assign core_hold_o = (state_reg != S_RUN);
   assign osc_run_o = osc_run;
   assign itv_timer_run_o = osc_run;
   assign resume_o = resume;
   assign branch_irq_o = branch;
   assign core_reset_o = (state_reg == S_RST);
   assign timer_req_flag_o = timer_req_flag_reg;
   assign ext_req_flag_o = ext_flag_reg;
   assign modulo_value_o = modulo_value_reg;
   assign data_buffer_word_o = dbf_reg;

   ////////////////////////////////////////////////////////////////////////
   // Helper: ticks seen in the current wait
   logic [8:0] wait_ticks_reg;
   always_ff @(posedge clock_i) begin
      if (srst_i || state_reg != S_WAIT) begin
         wait_ticks_reg <= 9'h000;
      end else if (tick) begin
         wait_ticks_reg <= wait_ticks_reg + 9'h001;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   sequence stop_exit_s;
      state_reg == S_STOP ##1 state_reg == S_WAIT;
   endsequence
   sequence halt_bad_s;
      state_reg == S_RUN && cmd_i.valid && !cmd_i.stop && !pin_rst &&
         cmd_i.operand != OPND_TMR && cmd_i.operand != OPND_KEY;
   endsequence

   halt_nop_a: assert property (halt_bad_s |->
      cmd_nop_o ##1 state_reg == S_RUN)
      else $error("bad halt operand did not act as no-op");
   halt02_gate_a: assert property (state_reg == S_RUN && cmd_i.valid &&
      !cmd_i.stop && cmd_i.operand == OPND_TMR && timer_req_flag_reg
      |=> state_reg != S_HALT02)
      else $error("halt 02H entered with timer flag set");
   halt08_gate_a: assert property (state_reg == S_RUN && cmd_i.valid &&
      !cmd_i.stop && cmd_i.operand == OPND_KEY && key_low
      |=> state_reg != S_HALT08)
      else $error("halt 08H entered with a key low");
   stop_osc_a: assert property (state_reg == S_STOP |->
      !osc_run_o && core_hold_o && !tick)
      else $error("oscillator running in stop");
   stop_wake_a: assert property (state_reg == S_STOP && key_low &&
      !pin_rst |=> state_reg == S_WAIT)
      else $error("low key did not release stop");
   wake_clear_a: assert property (stop_exit_s |->
      tmr_cnt_reg == 8'h00 && !timer_req_flag_reg && div_reg == '0)
      else $error("timer not restarted on stop release");
   wait_hold_a: assert property (state_reg == S_WAIT && !match_tick |->
      core_hold_o && osc_run_o && !resume_o)
      else $error("core released during wait");
   wait_len_a: assert property (state_reg == S_WAIT && match_tick &&
      !pin_rst |-> wait_ticks_reg == {1'b0, modulo_value_reg})
      else $error("wait length is not modulo plus one ticks");
   stop_gate_a: assert property (state_reg == S_RUN && cmd_i.valid &&
      cmd_i.stop && irq_en_i.ext && ext_flag_reg && !pin_rst
      |-> cmd_nop_o ##1 osc_run_o)
      else $error("stop taken with pin request pending");
   rst_len_a: assert property ($rose(state_reg == S_RST) |->
      rst_low && $past(low_cnt_reg) == RST_LIM)
      else $error("reset accepted before minimum low time");
   rst_init_a: assert property (state_reg == S_RST |=>
      data_buffer_word_o == DBF_RST && modulo_value_o == MOD_RST)
      else $error("reset did not load defaults");
   branch_a: assert property (branch_irq_o |->
      resume_o && global_irq_en_i)
      else $error("branch without resume or with interrupts off");
endmodule
`default_nettype wire

//--- logic/srs_sync3.sv
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/100ps
`default_nettype none
module srs_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic clock_i, // System clock
   input wire logic srst_i, // Synchronous reset
   input wire logic [W-1:0] d_i, // Asynchronous pins
   output logic [W-1:0] q_o // Filtered, synchronous pins
);
   logic [W-1:0] ff1_reg;
   logic [W-1:0] ff2_reg;
   logic [W-1:0] ff3_reg;
   logic [W-1:0] q_reg;
   wire logic [W-1:0] agree;

   ////////////////////////////////////////////////////////////////////////
   // Per-bit agreement of the two settled stages; the first stage is
   // left to the second flop alone to keep metastability contained
   assign agree = ~(ff2_reg ^ ff3_reg);

   // Shift chain and filtered output
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ff1_reg <= RST_VAL;
         ff2_reg <= RST_VAL;
         ff3_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         ff1_reg <= d_i;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
         q_reg <= (agree & ff3_reg) | (~agree & q_reg);
      end
   end

   assign q_o = q_reg;
endmodule
`default_nettype wire

//--- testbench/srs_core_model.sv
// Model of the core and key pins that face the sequencer
`timescale 1ns/100ps
`default_nettype none
module srs_core_model (
   input wire logic clock_i, // System clock
   output var srs_pkg::srs_cmd_t cmd_o, // Standby instruction
   output logic mod_wr_o, // Modulo load strobe
   output logic [7:0] mod_data_o, // Modulo value
   output logic [3:0] key_a_o, // Key port A pins
   output logic [11:0] key_bcd_o, // Key ports B to D pins
   output logic int_pin_o // Interrupt pin
);
   import srs_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   // Keys idle high through their pull-ups
   initial begin
      cmd_o = '0;
      mod_wr_o = 1'b0;
      mod_data_o = 8'h00;
      key_a_o = 4'hF;
      key_bcd_o = 12'hFFF;
      int_pin_o = 1'b0;
   end
   // One-cycle strobe; no flag is cleared just before, so an
   // enabled request cannot be lost ahead of a stop
   task automatic issue(input logic stp, input logic [3:0] op);
      @(negedge clock_i);
      cmd_o <= {1'b1, stp, op};
      @(negedge clock_i);
      cmd_o <= '0;
   endtask
   // Modulo goes in before any stop, so the restart wait is known
   task automatic load_mod(input logic [7:0] v);
      @(negedge clock_i);
      mod_wr_o <= 1'b1;
      mod_data_o <= v;
      @(negedge clock_i);
      mod_wr_o <= 1'b0;
      mod_data_o <= ~v; // Stale data must not look valid
   endtask
   // Pins move just after a falling edge
   task automatic pins(input logic [3:0] a, input logic [11:0] b,
      input logic p);
      @(negedge clock_i);
      key_a_o <= a;
      key_bcd_o <= b;
      int_pin_o <= p;
   endtask
endmodule
`default_nettype wire

//--- testbench/srs_standby_seq_tb_top.sv
// Self-checking bench for the standby and reset sequencer
`timescale 1ns/100ps
`default_nettype none
module srs_standby_seq_tb_top;
   import srs_pkg::*;
   logic clock_i = 1'b0, srst_i = 1'b1, rst_pin_n_i = 1'b1;
   srs_cmd_t cmd_i;
   logic [3:0] key_port_a_i;
   logic [11:0] key_bcd_i, key_bcd_used_i = 12'h0F0;
   logic int_pin_i, edge_select_flag_i = 1'b0, global_irq_en_i = 1'b0;
   srs_irq_t irq_en_i = '0;
   logic interval_timer_req_flag_i = 1'b0, tmr_flag_clr_i = 1'b0;
   logic ext_flag_clr_i = 1'b0, mod_wr_i, dbf_wr_i = 1'b0;
   logic [7:0] mod_data_i, modulo_value_o, rnd = 8'h14, v;
   logic [15:0] dbf_data_i = 16'h0000, data_buffer_word_o;
   logic cmd_nop_o, core_hold_o, osc_run_o, itv_timer_run_o, resume_o;
   logic branch_irq_o, core_reset_o, timer_req_flag_o, ext_req_flag_o;
   logic [2:0] q[$];
   int fails = 0, n_compared = 0, n, bad;
   // Short tick keeps the 256-tick waits inside the run budget
   localparam int TICK = 40;
   ////////////////////////////////////////////////////////////////////////
   // 100 ns clock
   always #50 clock_i = ~clock_i;
   srs_standby_seq #(.TICK_CYCLES(TICK)) dut (.clock_i, .srst_i,
      .rst_pin_n_i, .cmd_i,
      .key_port_a_i, .key_bcd_i, .key_bcd_used_i, .int_pin_i,
      .edge_select_flag_i, .irq_en_i, .global_irq_en_i,
      .interval_timer_req_flag_i, .tmr_flag_clr_i, .ext_flag_clr_i,
      .mod_wr_i, .mod_data_i, .dbf_wr_i, .dbf_data_i, .cmd_nop_o,
      .core_hold_o, .osc_run_o, .itv_timer_run_o, .resume_o,
      .branch_irq_o, .core_reset_o, .timer_req_flag_o, .ext_req_flag_o,
      .modulo_value_o, .data_buffer_word_o);
   srs_core_model m (.clock_i(clock_i), .cmd_o(cmd_i), .mod_wr_o(mod_wr_i),
      .mod_data_o(mod_data_i), .key_a_o(key_port_a_i),
      .key_bcd_o(key_bcd_i), .int_pin_o(int_pin_i));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string w, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", w, e, g);
      end
   endtask
   // Filter latency blurs the edge, so allow a few cycles
   task automatic near(input string w, input int e);
      chk(w, 32'h1, 32'(n >= e - 12 && n <= e + 12));
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clock_i);
   endtask
   task automatic clr(input logic t);
      tmr_flag_clr_i = t;
      ext_flag_clr_i = !t;
      cyc(1);
      tmr_flag_clr_i = 1'b0;
      ext_flag_clr_i = 1'b0;
   endtask
   // Note the expected nop pulse of a refused instruction, then issue it
   task automatic cmd(input logic stp, input logic [3:0] op,
      input logic ok);
      if (!ok) q.push_back(3'b100);
      m.issue(stp, op);
      chk("hold", 32'(ok), 32'(core_hold_o));
   endtask
   // Hold must stay up until resume; bounded so a hang still ends
   task automatic wait_res(input logic b);
      q.push_back({2'b01, b});
      n = 0;
      bad = 0;
      do begin
         @(posedge clock_i);
         n++;
         if (core_hold_o !== 1'b1) bad++;
      end while (resume_o !== 1'b1 && n < 15000);
      chk("hold in wait", 32'h0, 32'(bad));
      @(negedge clock_i);
   endtask
   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Each nop or resume pulse takes the oldest note
   always @(posedge clock_i) begin
      if (cmd_nop_o === 1'b1 || resume_o === 1'b1) begin
         if (q.size() == 0) begin
            chk("stray pulse", 32'h0, 32'h1);
         end else begin
            chk("pulse", 32'(q.pop_front()),
               32'({cmd_nop_o, resume_o, branch_irq_o}));
         end
      end
   end
   // Start wait and halt 02H wait, about 256 ticks each, plus short
   // waits fit well inside this span
   initial begin
      repeat (40000) @(posedge clock_i);
      fails++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(12);
      srst_i = 1'b0;
      chk("mod", 32'h00FF, 32'(modulo_value_o));
      chk("dbf", 32'h0320, 32'(data_buffer_word_o));
      chk("flags", 32'h0, 32'({timer_req_flag_o, ext_req_flag_o}));
      wait_res(1'b0);
      near("start wait", 256 * TICK);
      chk("tflag", 32'h1, 32'(timer_req_flag_o));
      $display("test start done");
      cmd(1'b0, OPND_TMR, 1'b0);
      clr(1'b1);
      for (int op = 0; op < 16; op++) begin
         if (op != 2 && op != 8) cmd(1'b0, op[3:0], 1'b0);
         if (op != 8) cmd(1'b1, op[3:0], 1'b0);
      end
      // Low on key A, then on a used B to D input
      for (int k = 0; k < 2; k++) begin
         m.pins(k ? 4'hF : 4'hE, k ? 12'hFEF : 12'hFFF, 1'b0);
         cyc(6);
         cmd(1'b0, OPND_KEY, 1'b0);
         cmd(1'b1, OPND_KEY, 1'b0);
      end
      irq_en_i.ext = 1'b1;
      m.pins(4'hF, 12'hFFF, 1'b1);
      cyc(6);
      chk("eflag", 32'h1, 32'(ext_req_flag_o));
      cmd(1'b1, OPND_KEY, 1'b0);
      cmd(1'b0, OPND_KEY, 1'b0);
      irq_en_i.ext = 1'b0;
      clr(1'b0);
      // Enabled interval request pending blocks halt 08H
      irq_en_i.itv = 1'b1;
      interval_timer_req_flag_i = 1'b1;
      cmd(1'b0, OPND_KEY, 1'b0);
      interval_timer_req_flag_i = 1'b0;
      irq_en_i.itv = 1'b0;
      $display("test refusals done");
      // Unused input low does not block the halt
      m.pins(4'hF, 12'hFFE, 1'b1);
      cyc(6);
      cmd(1'b0, OPND_KEY, 1'b1);
      cyc(10);
      m.pins(4'h7, 12'hFFE, 1'b1);
      wait_res(1'b0);
      m.load_mod(8'h00);
      global_irq_en_i = 1'b1;
      irq_en_i.tmr = 1'b1;
      clr(1'b1);
      cmd(1'b0, OPND_TMR, 1'b1);
      wait_res(1'b1);
      irq_en_i = '0;
      $display("test halt done");
      // Stop woken by key A, used key B to D, rising and falling pin
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         v = {6'h00, rnd[1:0]};
         edge_select_flag_i = (k == 3);
         global_irq_en_i = (k == 3);
         irq_en_i.ext = (k > 1);
         m.pins(4'hF, 12'hFFF, edge_select_flag_i);
         cyc(6);
         clr(1'b0);
         m.load_mod(v);
         cmd(1'b1, OPND_KEY, 1'b1);
         cyc(20);
         chk("osc", 32'h0, 32'({osc_run_o, itv_timer_run_o}));
         m.pins(k == 0 ? 4'h7 : 4'hF, k == 1 ? 12'hFEF : 12'hFFF,
            edge_select_flag_i ^ (k > 1));
         cyc(8);
         chk("osc", 32'h3, 32'({osc_run_o, itv_timer_run_o}));
         chk("tflag", 32'h0, 32'(timer_req_flag_o));
         wait_res(k == 3);
         near("stop wait", (32'(v) + 1) * TICK - 10);
         chk("tflag", 32'h1, 32'(timer_req_flag_o));
         m.pins(4'hF, 12'hFFF, int_pin_i);
         cyc(6);
      end
      global_irq_en_i = 1'b0;
      $display("test stop done");
      rnd = lfsr(rnd);
      dbf_data_i = {rnd, ~rnd};
      dbf_wr_i = 1'b1;
      cyc(1);
      dbf_wr_i = 1'b0;
      chk("dbf", 32'({rnd, ~rnd}), 32'(data_buffer_word_o));
      rst_pin_n_i = 1'b0;
      cyc(50);
      chk("short pin", 32'h0, 32'(core_reset_o));
      rst_pin_n_i = 1'b1;
      cyc(8);
      rst_pin_n_i = 1'b0;
      cyc(110);
      chk("pin reset", 32'h1, 32'(core_reset_o));
      chk("osc", 32'h0, 32'(osc_run_o));
      chk("dbf", 32'h0320, 32'(data_buffer_word_o));
      chk("mod", 32'h00FF, 32'(modulo_value_o));
      rst_pin_n_i = 1'b1;
      cyc(8);
      chk("osc hold", 32'h3, 32'({osc_run_o, core_hold_o}));
      $display("test pin reset done");
      chk("notes left", 32'h0, 32'(q.size()));
      close_out();
   end
endmodule
`default_nettype wire
